// ### astx_pkg.sv
// astx_pkg: register map, field layouts and constants of the async serial transceiver
`default_nettype none

package astx_pkg;

	// ==================================================================
	// register byte offsets
	localparam logic [7:0] ASTX_OFS_MODE   = 8'h00;
	localparam logic [7:0] ASTX_OFS_CTRL   = 8'h04;
	localparam logic [7:0] ASTX_OFS_STATUS = 8'h08;
	localparam logic [7:0] ASTX_OFS_TXDATA = 8'h0c;
	localparam logic [7:0] ASTX_OFS_RXDATA = 8'h10;
	localparam logic [7:0] ASTX_OFS_BAUD   = 8'h14;

	// ==================================================================
	// oversampling: sixteen ticks per bit, sample on the eighth
	localparam int         ASTX_OVERSAMPLE = 16;
	localparam logic [3:0] ASTX_SAMPLE_PT  = 4'h7;
	localparam logic [3:0] ASTX_SUB_LAST   = 4'hf;

	// ==================================================================
	// serial_mode_reg fields, bits 4..0
	typedef struct packed {
		logic char_length_sel; // 1: 7-bit data
		logic parity_enable;
		logic multiproc_mode;
		logic odd_parity;
		logic stop_two;
	} astx_mode_s;

	// serial_control_reg fields, bits 7..0
	typedef struct packed {
		logic tx_empty_irq_en;
		logic rx_irq_en;
		logic tx_enable;
		logic rx_enable;
		logic rsvd;
		logic tx_end_irq_en;
		logic clk_src_sel_hi;
		logic clk_src_sel_lo;
	} astx_ctrl_s;

	// serial_status_reg fields, bits 7..0
	typedef struct packed {
		logic tx_empty_flag;
		logic rx_full_flag;
		logic overrun_flag;
		logic framing_err_flag;
		logic parity_err_flag;
		logic tx_end_flag;
		logic multiproc_bit_rx;
		logic multiproc_bit_tx;
	} astx_status_s;

	localparam astx_mode_s   ASTX_MODE_RST   = 5'h00;
	localparam astx_ctrl_s   ASTX_CTRL_RST   = 8'h00;
	localparam astx_status_s ASTX_STATUS_RST = 8'h84;
	localparam logic [7:0]   ASTX_BAUD_RST   = 8'h00;

	typedef enum logic [2:0] {
		ASTX_TX_IDLE  = 3'h0,
		ASTX_TX_START = 3'h1,
		ASTX_TX_DATA  = 3'h2,
		ASTX_TX_PAR   = 3'h3,
		ASTX_TX_STOP  = 3'h4
	} astx_tx_e;

	typedef enum logic [2:0] {
		ASTX_RX_IDLE  = 3'h0,
		ASTX_RX_START = 3'h1,
		ASTX_RX_DATA  = 3'h2,
		ASTX_RX_PAR   = 3'h3,
		ASTX_RX_STOP  = 3'h4
	} astx_rx_e;

endpackage

`default_nettype wire

// ### astx_uart.sv
// astx_uart: asynchronous serial transceiver with a classic wishbone register slave
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - line idles high; low edge is a start bit; start, data lsb first, parity, stop.
// - receiver syncs on start falling edge, samples on eighth of sixteen ticks per bit.
// - twelve formats from char length, parity, multiprocessor and stop-length settings.
// - internal clock with output selected drives bit-rate clock rising at bit centre.
// - clock select 00 internal pin unused, 01 internal with output, 1x external input.
// - clearing transmit enable sets transmit-empty and resets the transmit shifter.
// - clearing receive enable keeps receive flags and receive data unchanged.
// - transmit-empty cleared by software means new data; copy it to the shifter.
// - after the copy set transmit-empty, start shifting, raise its interrupt if enabled.
// - send start 0, 7 or 8 data lsb first, parity or mp bit, stops, then mark.
// - at stop bit, reload if empty is 0, else set transmit-end and idle at mark.
// - shift received data lsb to msb, then take parity and stop bits.
// - check count of ones against even/odd selection when parity is enabled and multiprocessor mode is off.
// - the stop bit must be 1; with two stops only the first is checked.
// - all checks pass: move character to receive data and set receive-full.
// - character ends while receive-full set: set overrun, keep receive data.
// - parity or framing error sets its flag, character still transferred.
// - any receive error blocks receive-full and further reception until cleared.
// - with rx irq enable, request full interrupt and error interrupt on error flags.
module astx_uart #(
	parameter logic [7:0] BAUD_DIV_RST = astx_pkg::ASTX_BAUD_RST
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rxd_i,
	output logic             txd_o,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe_o,
	output logic             tx_empty_irq_o,
	output logic             tx_end_irq_o,
	output logic             rx_full_irq_o,
	output logic             rx_error_irq_o
);

	// ==================================================================
	// helpers
	function automatic logic data_parity(input logic [7:0] d, input logic short_char);
		data_parity = ^{d[7] & ~short_char, d[6:0]};
	endfunction

	function automatic logic [2:0] last_bit(input logic short_char);
		last_bit = short_char ? 3'h6 : 3'h7;
	endfunction

	// ==================================================================
	// state
	astx_pkg::astx_mode_s   mode_q;
	astx_pkg::astx_ctrl_s   ctrl_q;
	astx_pkg::astx_status_s stat_q;
	logic [7:0]             tx_data_reg_q;
	logic [7:0]             rx_data_reg_q;
	logic [7:0]             baud_div_q;
	logic [7:0]             baud_cnt_q;
	logic                   sck_prev_q;
	logic                   tick;
	logic                   ack_q;
	logic [31:0]            rdat_q;
	logic                   acc;
	logic                   wr_en;
	astx_pkg::astx_tx_e     tx_state_q;
	logic [3:0]             tx_sub_q;
	logic [2:0]             tx_bit_q;
	logic                   tx_stop2_q;
	logic [7:0]             tx_shift_reg_q;
	logic                   tx_bnd;
	logic                   tx_stop_last;
	logic                   tx_load;
	logic                   tx_line;
	logic                   txd_q;
	logic                   sck_q;
	astx_pkg::astx_rx_e     rx_state_q;
	logic [3:0]             rx_sub_q;
	logic [2:0]             rx_bit_q;
	logic [7:0]             rx_shift_reg_q;
	logic                   rx_par_q;
	logic                   rxd_prev_q;
	logic                   rx_err;
	logic                   rx_go;
	logic                   rx_smp;
	logic                   rx_done;
	logic                   rx_par_bad;
	logic                   st_wr;
	logic                   ext_clk;
	logic                   irq_txe_q;
	logic                   irq_tx_end_flag_q;
	logic                   irq_rxf_q;
	logic                   irq_rxe_q;

	// ==================================================================
	// wishbone slave: ack one cycle after the request, unmapped reads zero
	assign acc   = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_en = acc & wb_we_i & wb_sel_i[0];
	assign st_wr = wr_en & (wb_adr_i == astx_pkg::ASTX_OFS_STATUS);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			if (acc) begin
				case (wb_adr_i)
					astx_pkg::ASTX_OFS_MODE:   rdat_q <= {27'h0, mode_q};
					astx_pkg::ASTX_OFS_CTRL:   rdat_q <= {24'h0, ctrl_q};
					astx_pkg::ASTX_OFS_STATUS: rdat_q <= {24'h0, stat_q};
					astx_pkg::ASTX_OFS_TXDATA: rdat_q <= {24'h0, tx_data_reg_q};
					astx_pkg::ASTX_OFS_RXDATA: rdat_q <= {24'h0, rx_data_reg_q};
					astx_pkg::ASTX_OFS_BAUD:   rdat_q <= {24'h0, baud_div_q};
					default:                   rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q        <= astx_pkg::ASTX_MODE_RST;
			ctrl_q        <= astx_pkg::ASTX_CTRL_RST;
			tx_data_reg_q <= 8'h00;
			baud_div_q    <= BAUD_DIV_RST;
		end else if (wr_en) begin
			case (wb_adr_i)
				astx_pkg::ASTX_OFS_MODE:   mode_q        <= wb_dat_i[4:0];
				astx_pkg::ASTX_OFS_CTRL:   ctrl_q        <= {wb_dat_i[7:4], 1'b0, wb_dat_i[2:0]};
				astx_pkg::ASTX_OFS_TXDATA: tx_data_reg_q <= wb_dat_i[7:0];
				astx_pkg::ASTX_OFS_BAUD:   baud_div_q    <= wb_dat_i[7:0];
				default:                   ;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ==================================================================
	// sixteen-times clock: baud divider or rising edges on the clock pin
	assign ext_clk = ctrl_q.clk_src_sel_hi;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_cnt_q <= 8'h00;
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_i;
			baud_cnt_q <= (baud_cnt_q >= baud_div_q) ? 8'h00 : baud_cnt_q + 8'h01;
		end
	end

	// the external source already runs at sixteen times the bit rate
	assign tick = ext_clk ? (sck_i & ~sck_prev_q) : (baud_cnt_q >= baud_div_q);

	// ==================================================================
	// transmitter
	assign tx_bnd       = tick & (tx_sub_q == astx_pkg::ASTX_SUB_LAST);
	assign tx_stop_last = (tx_state_q == astx_pkg::ASTX_TX_STOP) & (~mode_q.stop_two | tx_stop2_q);
	assign tx_load      = tx_bnd & ctrl_q.tx_enable & ~stat_q.tx_empty_flag
	                    & ((tx_state_q == astx_pkg::ASTX_TX_IDLE) | tx_stop_last);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_q     <= astx_pkg::ASTX_TX_IDLE;
			tx_sub_q       <= 4'h0;
			tx_bit_q       <= 3'h0;
			tx_stop2_q     <= 1'b0;
			tx_shift_reg_q <= 8'h00;
		end else if (!ctrl_q.tx_enable) begin
			tx_state_q     <= astx_pkg::ASTX_TX_IDLE;
			tx_shift_reg_q <= 8'h00;
			tx_sub_q       <= 4'h0;
			tx_bit_q       <= 3'h0;
			tx_stop2_q     <= 1'b0;
		end else begin
			if (tick)
				tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_load) begin
				tx_shift_reg_q <= tx_data_reg_q;
				tx_state_q     <= astx_pkg::ASTX_TX_START;
				tx_bit_q       <= 3'h0;
				tx_stop2_q     <= 1'b0;
			end else if (tx_bnd) begin
				case (tx_state_q)
					astx_pkg::ASTX_TX_START: tx_state_q <= astx_pkg::ASTX_TX_DATA;
					astx_pkg::ASTX_TX_DATA: begin
						tx_bit_q <= tx_bit_q + 3'h1;
						if (tx_bit_q == last_bit(mode_q.char_length_sel)) begin
							if (mode_q.parity_enable | mode_q.multiproc_mode)
								tx_state_q <= astx_pkg::ASTX_TX_PAR;
							else
								tx_state_q <= astx_pkg::ASTX_TX_STOP;
						end
					end
					astx_pkg::ASTX_TX_PAR:   tx_state_q <= astx_pkg::ASTX_TX_STOP;
					astx_pkg::ASTX_TX_STOP: begin
						if (tx_stop_last)
							tx_state_q <= astx_pkg::ASTX_TX_IDLE;
						else
							tx_stop2_q <= 1'b1;
					end
					default: tx_state_q <= astx_pkg::ASTX_TX_IDLE;
				endcase
			end
		end
	end

	// line level per state, registered together with the bit clock
	always_comb begin
		case (tx_state_q)
			astx_pkg::ASTX_TX_START: tx_line = 1'b0;
			astx_pkg::ASTX_TX_DATA:  tx_line = tx_shift_reg_q[tx_bit_q];
			astx_pkg::ASTX_TX_PAR:   tx_line = mode_q.multiproc_mode ? stat_q.multiproc_bit_tx
			                         : data_parity(tx_shift_reg_q, mode_q.char_length_sel)
			                           ^ mode_q.odd_parity;
			default:                 tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_q <= 1'b1;
			sck_q <= 1'b0;
		end else begin
			txd_q <= tx_line;
			sck_q <= tx_sub_q[3];
		end
	end

	assign txd_o    = txd_q;
	assign sck_o    = sck_q;
	assign sck_oe_o = ~ctrl_q.clk_src_sel_hi & ctrl_q.clk_src_sel_lo;

	// ==================================================================
	// receiver
	assign rx_err     = stat_q.overrun_flag | stat_q.framing_err_flag | stat_q.parity_err_flag;
	assign rx_go      = ctrl_q.rx_enable & ~rx_err;
	assign rx_smp     = tick & (rx_sub_q == astx_pkg::ASTX_SAMPLE_PT);
	// a frame cut by clearing receive enable must not touch data or flags
	assign rx_done    = rx_go & rx_smp & (rx_state_q == astx_pkg::ASTX_RX_STOP);
	assign rx_par_bad = mode_q.parity_enable & ~mode_q.multiproc_mode
	                  & (data_parity(rx_shift_reg_q, mode_q.char_length_sel)
	                     ^ rx_par_q ^ mode_q.odd_parity);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state_q     <= astx_pkg::ASTX_RX_IDLE;
			rx_sub_q       <= 4'h0;
			rx_bit_q       <= 3'h0;
			rx_shift_reg_q <= 8'h00;
			rx_par_q       <= 1'b0;
			rxd_prev_q     <= 1'b1;
		end else begin
			rxd_prev_q <= rxd_i;
			if (!rx_go) begin
				rx_state_q <= astx_pkg::ASTX_RX_IDLE;
			end else if (rx_state_q == astx_pkg::ASTX_RX_IDLE) begin
				if (rxd_prev_q & ~rxd_i) begin
					rx_state_q <= astx_pkg::ASTX_RX_START;
					rx_sub_q   <= 4'h0;
				end
			end else begin
				if (tick)
					rx_sub_q <= rx_sub_q + 4'h1;
				if (rx_smp) begin
					case (rx_state_q)
						astx_pkg::ASTX_RX_START: begin
							// a high level at the start centre was a glitch
							rx_state_q     <= rxd_i ? astx_pkg::ASTX_RX_IDLE
							                        : astx_pkg::ASTX_RX_DATA;
							rx_bit_q       <= 3'h0;
							rx_shift_reg_q <= 8'h00;
						end
						astx_pkg::ASTX_RX_DATA: begin
							rx_shift_reg_q[rx_bit_q] <= rxd_i;
							rx_bit_q                 <= rx_bit_q + 3'h1;
							if (rx_bit_q == last_bit(mode_q.char_length_sel)) begin
								if (mode_q.parity_enable | mode_q.multiproc_mode)
									rx_state_q <= astx_pkg::ASTX_RX_PAR;
								else
									rx_state_q <= astx_pkg::ASTX_RX_STOP;
							end
						end
						astx_pkg::ASTX_RX_PAR: begin
							rx_par_q   <= rxd_i;
							rx_state_q <= astx_pkg::ASTX_RX_STOP;
						end
						// only the first stop is looked at
						astx_pkg::ASTX_RX_STOP:  rx_state_q <= astx_pkg::ASTX_RX_IDLE;
						default:                 rx_state_q <= astx_pkg::ASTX_RX_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rx_data_reg_q <= 8'h00;
		else if (rx_done & ~stat_q.rx_full_flag)
			rx_data_reg_q <= rx_shift_reg_q;
	end

	// ==================================================================
	// status flags: software writes 0 to clear, hardware set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= astx_pkg::ASTX_STATUS_RST;
		end else begin
			if (st_wr) begin
				stat_q.tx_empty_flag    <= stat_q.tx_empty_flag & wb_dat_i[7];
				stat_q.rx_full_flag     <= stat_q.rx_full_flag & wb_dat_i[6];
				stat_q.overrun_flag     <= stat_q.overrun_flag & wb_dat_i[5];
				stat_q.framing_err_flag <= stat_q.framing_err_flag & wb_dat_i[4];
				stat_q.parity_err_flag  <= stat_q.parity_err_flag & wb_dat_i[3];
				stat_q.tx_end_flag      <= stat_q.tx_end_flag & wb_dat_i[2];
				stat_q.multiproc_bit_tx <= wb_dat_i[0];
			end
			if (!ctrl_q.tx_enable) begin
				stat_q.tx_empty_flag <= 1'b1;
				stat_q.tx_end_flag   <= 1'b1;
			end else if (tx_load) begin
				stat_q.tx_empty_flag <= 1'b1;
				stat_q.tx_end_flag   <= 1'b0;
			end else if (tx_bnd & tx_stop_last & stat_q.tx_empty_flag) begin
				stat_q.tx_end_flag <= 1'b1;
			end
			if (rx_done) begin
				if (stat_q.rx_full_flag) begin
					stat_q.overrun_flag <= 1'b1;
				end else begin
					if (!rxd_i)
						stat_q.framing_err_flag <= 1'b1;
					if (rx_par_bad)
						stat_q.parity_err_flag <= 1'b1;
					if (rxd_i & ~rx_par_bad)
						stat_q.rx_full_flag <= 1'b1;
					stat_q.multiproc_bit_rx <= rx_par_q & mode_q.multiproc_mode;
				end
			end
		end
	end

	// ==================================================================
	// interrupt requests, levels following flags and enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_txe_q  <= 1'b0;
			irq_tx_end_flag_q <= 1'b0;
			irq_rxf_q  <= 1'b0;
			irq_rxe_q  <= 1'b0;
		end else begin
			irq_txe_q  <= stat_q.tx_empty_flag & ctrl_q.tx_empty_irq_en;
			irq_tx_end_flag_q <= stat_q.tx_end_flag & ctrl_q.tx_end_irq_en;
			irq_rxf_q  <= stat_q.rx_full_flag & ctrl_q.rx_irq_en;
			irq_rxe_q  <= rx_err & ctrl_q.rx_irq_en;
		end
	end

	assign tx_empty_irq_o = irq_txe_q;
	assign tx_end_irq_o   = irq_tx_end_flag_q;
	assign rx_full_irq_o  = irq_rxf_q;
	assign rx_error_irq_o = irq_rxe_q;

	// ==================================================================
	// checks
	property p_tx_idle_mark;
		@(posedge clk_i) disable iff (rst_i)
		tx_state_q == astx_pkg::ASTX_TX_IDLE |=> txd_o;
	endproperty
	a_tx_idle_mark: assert property (p_tx_idle_mark) else $error("line not at mark when idle");

	property p_tx_start_low;
		@(posedge clk_i) disable iff (rst_i)
		tx_load |=> ##1 !txd_o;
	endproperty
	a_tx_start_low: assert property (p_tx_start_low) else $error("start bit not low");

	property p_te_off_empty;
		@(posedge clk_i) disable iff (rst_i)
		!ctrl_q.tx_enable |=> stat_q.tx_empty_flag && tx_state_q == astx_pkg::ASTX_TX_IDLE;
	endproperty
	a_te_off_empty: assert property (p_te_off_empty) else $error("tx disable did not reset");

	property p_re_off_hold;
		@(posedge clk_i) disable iff (rst_i)
		!ctrl_q.rx_enable |=> $stable(rx_data_reg_q) && !$rose(stat_q.rx_full_flag);
	endproperty
	a_re_off_hold: assert property (p_re_off_hold) else $error("rx state moved while off");

	property p_load_sets_empty;
		@(posedge clk_i) disable iff (rst_i)
		tx_load |=> stat_q.tx_empty_flag && tx_shift_reg_q == $past(tx_data_reg_q);
	endproperty
	a_load_sets_empty: assert property (p_load_sets_empty) else $error("load failed");

	property p_overrun;
		@(posedge clk_i) disable iff (rst_i)
		rx_done && stat_q.rx_full_flag |=> stat_q.overrun_flag && $stable(rx_data_reg_q);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not handled");

	property p_err_blocks;
		@(posedge clk_i) disable iff (rst_i)
		rx_err |=> rx_state_q == astx_pkg::ASTX_RX_IDLE;
	endproperty
	a_err_blocks: assert property (p_err_blocks) else $error("reception ran with error");

	property p_rx_irq;
		@(posedge clk_i) disable iff (rst_i)
		stat_q.rx_full_flag && ctrl_q.rx_irq_en |=> rx_full_irq_o;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx full irq missing");

	property p_sck_centre;
		@(posedge clk_i) disable iff (rst_i)
		tick && tx_sub_q == 4'h7 |=> ##1 sck_o;
	endproperty
	a_sck_centre: assert property (p_sck_centre) else $error("bit clock not high at centre");

	property p_tx_end;
		@(posedge clk_i) disable iff (rst_i)
		ctrl_q.tx_enable && tx_bnd && tx_stop_last && stat_q.tx_empty_flag |=> stat_q.tx_end_flag;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx end not set");

	property p_parity_err;
		@(posedge clk_i) disable iff (rst_i)
		rx_done && !stat_q.rx_full_flag && rx_par_bad
		|=> stat_q.parity_err_flag && !stat_q.rx_full_flag;
	endproperty
	a_parity_err: assert property (p_parity_err) else $error("parity error missed");

	c_tx_frame:  cover property (@(posedge clk_i) disable iff (rst_i) tx_load);
	c_rx_ok:     cover property (@(posedge clk_i) disable iff (rst_i) $rose(stat_q.rx_full_flag));
	c_overrun:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(stat_q.overrun_flag));
	c_frame_err: cover property (@(posedge clk_i) disable iff (rst_i) $rose(stat_q.framing_err_flag));

endmodule // astx_uart

`default_nettype wire

// ### astx_remote.sv
// astx_remote: far-side serial device model, drives rxd and decodes txd
`timescale 1ns/1ps
`default_nettype none
module astx_remote #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	int          fbits = 10;
	logic [11:0] got[$];
	logic [11:0] w;
	// ==========
	// sender: mark when idle, low start, bits lsb first
	initial rxd_o = 1'b1;
	task automatic send(input logic [11:0] bits, input int n);
		rxd_o <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rxd_o <= bits[i];
			repeat (BIT_CLKS) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask
	// ==========
	// receiver: sync on falling edge, sample each bit centre
	always begin
		@(negedge txd_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		w = '0;
		for (int i = 0; i < fbits; i++) begin
			repeat (BIT_CLKS) @(posedge clk_i);
			w[i] = txd_i;
		end
		got.push_back(w);
	end
endmodule // astx_remote
`default_nettype wire

// ### astx_uart_test.sv
// astx_uart_test: self-checking bench for the async serial transceiver
`timescale 1ns/1ps
`default_nettype none
module astx_uart_test;
	localparam int BC = 32;
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic        sck_i    = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        rxd;
	logic        txd_o;
	logic        sck_o;
	logic        sck_oe_o;
	logic        tx_empty_irq_o;
	logic        tx_end_irq_o;
	logic        rx_full_irq_o;
	logic        rx_error_irq_o;
	int          num_errors = 0;
	int          n_tests    = 0;
	logic [31:0] rng        = 32'hea37;
	logic [7:0]  rd;
	logic [7:0]  d;
	logic [7:0]  ed;
	always #12.5 clk_i = ~clk_i;
	// external 16x clock, never stopped
	always @(posedge clk_i) sck_i <= ~sck_i;
	astx_uart #(.BAUD_DIV_RST(8'h01)) i_astx_uart (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i(rxd),
		.txd_o, .sck_i, .sck_o, .sck_oe_o, .tx_empty_irq_o, .tx_end_irq_o,
		.rx_full_irq_o, .rx_error_irq_o);
	astx_remote #(.BIT_CLKS(BC)) i_astx_remote (.clk_i, .txd_i(txd_o), .rxd_o(rxd));
	// ==========
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: value %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: pin %b want %b", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, wd};
		// hold the request until ack is seen; only the watchdog ends this wait
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk({4'h0, rd}, {4'h0, exp});
	endtask
	task automatic wait_tx(input int n);
		while (i_astx_remote.got.size() < n)
			@(posedge clk_i);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_i);
		num_errors++;
		finish_test();
	end
	// ==========
	// main sequence
	initial begin : main
		logic [11:0] ew;
		logic [7:0]  st[5];
		int          nb;
		int          ex;
		time         t0;
		st = '{8'hc4, 8'he4, 8'h8c, 8'h94, 8'hc4};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(8'h08, 8'h84);
		rdc(8'h04, 8'h00);
		rdc(8'h1c, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 32; m++) begin
			wb(1'b1, 8'h04, 8'h00);
			wb(1'b1, 8'h00, 8'(m));
			wb(1'b1, 8'h04, 8'ha0 | 8'(m % 3));
			chk_pin(sck_oe_o, m % 3 == 1);
			rng = xs(rng);
			d = rng[7:0];
			nb = m[4] ? 7 : 8;
			ex = int'(m[2] | m[3]);
			ew = {4'h0, d} & (m[4] ? 12'h07f : 12'h0ff);
			if (ex == 1) ew[nb] = m[2] | (^ew ^ m[1]);
			ew[nb + ex] = 1'b1;
			i_astx_remote.fbits = nb + ex + 1;
			i_astx_remote.got.delete();
			wb(1'b1, 8'h0c, d);
			wb(1'b1, 8'h08, 8'h7f);
			// bit-rate clock must rise half a bit after the start edge
			if (m % 3 == 1) begin
				@(negedge txd_o);
				t0 = $time;
				@(posedge sck_o);
				chk(12'($time - t0), 12'(BC * 25 / 2));
			end
			wait_tx(1);
			chk(i_astx_remote.got[0], ew);
			repeat (2 * BC) @(posedge clk_i);
			rdc(8'h08, 8'h85);
			chk_pin(tx_empty_irq_o, 1'b1);
		end
		$display("test formats done");
		wb(1'b1, 8'h04, 8'h00);
		wb(1'b1, 8'h00, 8'h00);
		wb(1'b1, 8'h04, 8'ha4);
		i_astx_remote.fbits = 9;
		i_astx_remote.got.delete();
		wb(1'b1, 8'h0c, 8'h5a);
		wb(1'b1, 8'h08, 8'h7e);
		// the write above already returned the old status, so poll afresh
		do wb(1'b0, 8'h08, 8'h00); while (rd[7] !== 1'b1);
		wb(1'b1, 8'h0c, 8'hc3);
		wb(1'b1, 8'h08, 8'h7e);
		wait_tx(2);
		chk(i_astx_remote.got[0], 12'h15a);
		chk(i_astx_remote.got[1], 12'h1c3);
		repeat (2 * BC) @(posedge clk_i);
		chk_pin(tx_end_irq_o, 1'b1);
		$display("test queued bytes done");
		wb(1'b1, 8'h0c, 8'h00);
		wb(1'b1, 8'h08, 8'h7e);
		repeat (3 * BC) @(posedge clk_i);
		wb(1'b1, 8'h04, 8'h00);
		rdc(8'h08, 8'h84);
		chk_pin(txd_o, 1'b1);
		repeat (12 * BC) @(posedge clk_i);
		$display("test transmit disable done");
		wb(1'b1, 8'h00, 8'h08);
		wb(1'b1, 8'h04, 8'h50);
		for (int j = 0; j < 5; j++) begin
			rng = xs(rng);
			d = rng[7:0];
			if (j != 1) ed = d;
			i_astx_remote.send({2'b00, j != 3, ^d ^ (j == 2), d}, 10);
			repeat (BC) @(posedge clk_i);
			rdc(8'h08, st[j]);
			rdc(8'h10, ed);
			chk_pin(rx_full_irq_o, st[j][6]);
			chk_pin(rx_error_irq_o, |st[j][5:3]);
			if (j == 1) begin
				wb(1'b1, 8'h04, 8'h40);
				rdc(8'h08, 8'he4);
				rdc(8'h10, ed);
				wb(1'b1, 8'h04, 8'h50);
			end
			// clearing the flags lets reception resume
			if (j != 0) wb(1'b1, 8'h08, 8'h84);
		end
		// 7-bit multiprocessor frame, two stops, external sixteen-times clock
		wb(1'b1, 8'h04, 8'h00);
		wb(1'b1, 8'h00, 8'h17);
		wb(1'b1, 8'h04, 8'h52);
		rng = xs(rng);
		d = rng[7:0];
		i_astx_remote.send({5'b00111, d[6:0]}, 10);
		repeat (BC) @(posedge clk_i);
		rdc(8'h08, 8'hc6);
		rdc(8'h10, {1'b0, d[6:0]});
		chk_pin(rx_full_irq_o, 1'b1);
		$display("test receive done");
		finish_test();
	end
endmodule // astx_uart_test
`default_nettype wire
